// ==== rtl/adc_ctl_pkg.sv ====
// Purpose: shared constants of the converter control and readout block
// Assumes: 8-bit register bus, register offsets are the low address nibble
// Notes:   all counts are in system clock cycles (states)
package adc_ctl_pkg;

  // ************************************************************
  // register offsets (low nibble of the byte address)
  // ************************************************************
  localparam logic [3:0] OFF_RESULT_A_HI = 4'h0;
  localparam logic [3:0] OFF_RESULT_A_LO = 4'h1;
  localparam logic [3:0] OFF_RESULT_B_HI = 4'h2;
  localparam logic [3:0] OFF_RESULT_B_LO = 4'h3;
  localparam logic [3:0] OFF_RESULT_C_HI = 4'h4;
  localparam logic [3:0] OFF_RESULT_C_LO = 4'h5;
  localparam logic [3:0] OFF_RESULT_D_HI = 4'h6;
  localparam logic [3:0] OFF_RESULT_D_LO = 4'h7;
  localparam logic [3:0] OFF_CTRL_STATUS = 4'h8;
  localparam logic [3:0] OFF_TRIG_CTRL   = 4'h9;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int END_FLAG_BIT   = 7;
  localparam int IRQ_ENABLE_BIT = 6;
  localparam int START_BIT      = 5;
  localparam int SCAN_MODE_BIT  = 4;
  localparam int TIME_SEL_BIT   = 3;
  localparam int GROUP_SEL_BIT  = 2;
  localparam int TRIG_EN_BIT    = 7;

  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] TRIG_CTRL_RESET   = 8'h7F;
  localparam logic [7:0] TRIG_FIXED_ONES   = 8'h7F;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;
  localparam int         RESULT_W          = 10;
  localparam logic [9:0] RESULT_RESET      = 10'h000;

  // ************************************************************
  // conversion lengths in states
  // ************************************************************
  localparam logic [8:0] CONV_SLOW_FIRST = 9'h10A;  // 266
  localparam logic [8:0] CONV_FAST_FIRST = 9'h086;  // 134
  localparam logic [8:0] CONV_SLOW_NEXT  = 9'h100;  // 256
  localparam logic [8:0] CONV_FAST_NEXT  = 9'h080;  // 128

endpackage

// ==== rtl/conv_if.sv ====
// Purpose: carrier between sequencer, conversion timer and result store
// Assumes: one clock domain
// Notes:   ctl drives, timer and store answer
`timescale 1ns/1ns
`default_nettype none
interface conv_if;
  logic       load;       // start timing one conversion
  logic       stop;       // abandon the running conversion
  logic [8:0] length;     // conversion length in states
  logic       done;       // one-cycle pulse at conversion end
  logic       clear;      // standby wipe of the results
  logic       wrEn;
  logic [1:0] wrIdx;
  logic [9:0] wrData;
  logic       rdEn;
  logic [1:0] rdIdx;
  logic [9:0] rdData;

  modport ctl   (output load, stop, length, clear, wrEn, wrIdx, wrData, rdEn, rdIdx, input done, rdData);
  modport timer (input load, stop, length, clear, output done);
  modport store (input clear, wrEn, wrIdx, wrData, rdEn, rdIdx, output rdData);
endinterface
`default_nettype wire

// ==== rtl/conv_timer.sv ====
// Purpose: counts the states of one conversion and pulses done at its end
// Assumes: length is at least two when load is high
// Notes:   stop or clear abandons the count without a done pulse
`timescale 1ns/1ns
`default_nettype none
module conv_timer (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  conv_if.timer     cv
);
  logic [8:0] remain;
  logic       running;

  // ************************************************************
  // down counter
  // ************************************************************
  // done is registered so the sequencer sees a clean pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      remain  <= 9'h000;
      running <= 1'b0;
      cv.done <= 1'b0;
    end else if (ce) begin
      cv.done <= 1'b0;
      if (cv.stop || cv.clear) begin
        running <= 1'b0;
      end else if (cv.load) begin
        remain  <= cv.length;
        running <= 1'b1;
      end else if (running) begin
        if (remain == 9'h002) begin
          cv.done <= 1'b1;   // pulse lands on the last state
          running <= 1'b0;
        end else begin
          remain <= 9'(remain - 9'h001);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/result_store.sv ====
// Purpose: four conversion results with a registered read port
// Assumes: one write and one read port, same clock
// Notes:   read data appear one cycle after rdEn
`timescale 1ns/1ns
`default_nettype none
module result_store #(
  parameter int DEPTH = 4
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  conv_if.store     cv
);
  logic [adc_ctl_pkg::RESULT_W-1:0] mem [DEPTH];

  // ************************************************************
  // storage and read register
  // ************************************************************
  // standby wipes every word, as a reset does
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= adc_ctl_pkg::RESULT_RESET;
      end
      cv.rdData <= adc_ctl_pkg::RESULT_RESET;
    end else if (ce) begin
      if (cv.clear) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem[i] <= adc_ctl_pkg::RESULT_RESET;
        end
      end else if (cv.wrEn) begin
        mem[cv.wrIdx] <= cv.wrData;
      end
      if (cv.clear) begin
        cv.rdData <= adc_ctl_pkg::RESULT_RESET;
      end else if (cv.rdEn) begin
        cv.rdData <= mem[cv.rdIdx];
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/adc_control_and_readout.sv ====
// Purpose: control, status and byte-wide result readout of an 8-channel converter
// Assumes: analog core outside; it converts sampleChannel and presents convResult
//          at least by the done pulse; standby is a same-clock level
// Notes:   register reads answer two cycles after the strobe, with regAck
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - channel n of group stores to result n
// - control/status register 8 bits, cleared
// - end flag on single end or scan pass
// - flag clears by zero after read-as-one
// - bit 6 gates end interrupt request
// - start bit starts, holds, single clears
// - scan cycles until cleared, reset, standby
// - bit 4 picks single or scan
// - bit 3 picks 266 or 134 states
// - single: group bit plus channel bits
// - scan: first channel up to selected
// - trigger register 8 bits, resets 0x7F
// - trigger enable allows falling-edge start
// - trigger low bits read one, ignore writes
// - upper read latches lower byte
// - lower read returns latched byte
// - result left-justified, low six bits zero
// - results cleared on reset and standby
// - later scan conversions 256 or 128 states
module adc_control_and_readout (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       standby,
  input  wire logic       regSel,
  input  wire logic [3:0] regAddr,
  input  wire logic       regRead,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  output var  logic [7:0] regRdata,
  output var  logic       regAck,
  input  wire logic       extTriggerIn,
  input  wire logic [9:0] convResult,
  output var  logic [2:0] sampleChannel,
  output var  logic       convBusy,
  output var  logic       convEndIrq
);

  // ************************************************************
  // declarations
  // ************************************************************
  typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} seq_state_t;

  conv_if cv ();

  seq_state_t seqState;
  seq_state_t next_seqState;

  // control/status fields
  logic       convEndFlag;
  logic       endIrqEnable;
  logic       convStartBit;
  logic       scanMode;
  logic       convTimeSelect;
  logic       groupSelect;
  logic [1:0] channelSel;
  logic       flagReadArmed;

  // trigger control field
  logic       extTriggerEnable;

  // trigger pin synchroniser and edge detect
  logic       trigMeta;
  logic       trigSync;
  logic       trigPrev;
  logic       trigFall;

  // sequencing
  logic [1:0] activeChan;
  logic [1:0] next_activeChan;
  logic       storeNow;
  logic       passEnd;

  // bus decode
  logic       busRead;
  logic       ctrlWrite;
  logic       trigWrite;
  logic       startSet;
  logic       startClear;

  // read pipeline and holding latch
  logic       rdPend;
  logic [3:0] rdAddr;
  logic [7:0] holdLatch;
  logic [7:0] ctrlView;
  logic [7:0] trigView;
  logic [7:0] next_rdata;

  // ************************************************************
  // sub-blocks
  // ************************************************************
  conv_timer timerInst (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .cv      (cv.timer)
  );

  result_store #(
    .DEPTH (4)
  ) storeInst (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .cv      (cv.store)
  );

  // ************************************************************
  // bus decode
  // ************************************************************
  // writes to result offsets and unmapped offsets are dropped
  assign busRead   = regSel && regRead;
  assign ctrlWrite = regSel && regWrite && (regAddr == adc_ctl_pkg::OFF_CTRL_STATUS);
  assign trigWrite = regSel && regWrite && (regAddr == adc_ctl_pkg::OFF_TRIG_CTRL);

  assign trigFall   = extTriggerEnable && trigPrev && !trigSync;
  assign startSet   = (ctrlWrite && regWdata[adc_ctl_pkg::START_BIT]) || trigFall;
  assign startClear = ctrlWrite && !regWdata[adc_ctl_pkg::START_BIT];

  // ************************************************************
  // external trigger pin
  // ************************************************************
  // two flops against metastability, a third for the edge; idle level high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigMeta <= 1'b1;
      trigSync <= 1'b1;
      trigPrev <= 1'b1;
    end else if (ce) begin
      trigMeta <= extTriggerIn;
      trigSync <= trigMeta;
      trigPrev <= trigSync;
    end
  end

  // ************************************************************
  // conversion sequencing
  // ************************************************************
  // a done pulse counts only while the start bit still stands
  assign storeNow = (seqState == ST_CONVERT) && convStartBit && cv.done;
  assign passEnd  = storeNow && (!scanMode || (activeChan == channelSel));

  // next state and channel of the sequencer
  always_comb begin
    next_seqState   = seqState;
    next_activeChan = activeChan;
    cv.load         = 1'b0;
    cv.stop         = 1'b0;
    case (seqState)
      ST_IDLE: begin
        if (convStartBit) begin
          next_activeChan = scanMode ? 2'b00 : channelSel;
          cv.load         = 1'b1;
          next_seqState   = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!convStartBit) begin
          cv.stop       = 1'b1;
          next_seqState = ST_IDLE;
        end else if (cv.done) begin
          if (!scanMode) begin
            next_seqState = ST_IDLE;
          end else begin
            next_activeChan = passEnd ? 2'b00 : 2'(activeChan + 2'b01);
            cv.load         = 1'b1;
          end
        end
      end
      default: begin
        next_seqState = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    // only a load from idle is a first conversion; a scan reload never is
    if (seqState == ST_IDLE) begin
      cv.length = convTimeSelect ? adc_ctl_pkg::CONV_FAST_FIRST : adc_ctl_pkg::CONV_SLOW_FIRST;
    end else begin
      cv.length = convTimeSelect ? adc_ctl_pkg::CONV_FAST_NEXT : adc_ctl_pkg::CONV_SLOW_NEXT;
    end
  end

  // sequencer registers; standby stops everything
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seqState   <= ST_IDLE;
      activeChan <= 2'b00;
    end else if (ce) begin
      if (standby) begin
        seqState   <= ST_IDLE;
        activeChan <= 2'b00;
      end else begin
        seqState   <= next_seqState;
        activeChan <= next_activeChan;
      end
    end
  end

  assign cv.wrEn   = storeNow && !standby;
  assign cv.wrIdx  = activeChan;
  assign cv.wrData = convResult;
  assign cv.clear  = standby;

  // ************************************************************
  // control/status register
  // ************************************************************
  // cleared on reset and standby
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      endIrqEnable   <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::IRQ_ENABLE_BIT];
      scanMode       <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::SCAN_MODE_BIT];
      convTimeSelect <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::TIME_SEL_BIT];
      groupSelect    <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::GROUP_SEL_BIT];
      channelSel     <= adc_ctl_pkg::CTRL_STATUS_RESET[1:0];
    end else if (ce) begin
      if (standby) begin
        endIrqEnable   <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::IRQ_ENABLE_BIT];
        scanMode       <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::SCAN_MODE_BIT];
        convTimeSelect <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::TIME_SEL_BIT];
        groupSelect    <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::GROUP_SEL_BIT];
        channelSel     <= adc_ctl_pkg::CTRL_STATUS_RESET[1:0];
      end else if (ctrlWrite) begin
        endIrqEnable   <= regWdata[adc_ctl_pkg::IRQ_ENABLE_BIT];
        scanMode       <= regWdata[adc_ctl_pkg::SCAN_MODE_BIT];
        convTimeSelect <= regWdata[adc_ctl_pkg::TIME_SEL_BIT];
        groupSelect    <= regWdata[adc_ctl_pkg::GROUP_SEL_BIT];
        channelSel     <= regWdata[1:0];
      end
    end
  end

  // cleared only by software, reset, standby in scan
  // a set request beats the automatic single-mode clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      convStartBit <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::START_BIT];
    end else if (ce) begin
      if (standby) begin
        convStartBit <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::START_BIT];
      end else if (startClear && !trigFall) begin
        convStartBit <= 1'b0;
      end else if (startSet) begin
        convStartBit <= 1'b1;
      end else if (passEnd && !scanMode) begin
        convStartBit <= 1'b0;
      end
    end
  end

  // cleared by zero after read-as-one; a set in the same cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      convEndFlag   <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::END_FLAG_BIT];
      flagReadArmed <= 1'b0;
    end else if (ce) begin
      if (standby) begin
        convEndFlag   <= adc_ctl_pkg::CTRL_STATUS_RESET[adc_ctl_pkg::END_FLAG_BIT];
        flagReadArmed <= 1'b0;
      end else if (passEnd) begin
        convEndFlag <= 1'b1;
      end else if (ctrlWrite && flagReadArmed && !regWdata[adc_ctl_pkg::END_FLAG_BIT]) begin
        convEndFlag   <= 1'b0;
        flagReadArmed <= 1'b0;
      end else if (busRead && (regAddr == adc_ctl_pkg::OFF_CTRL_STATUS) && convEndFlag) begin
        flagReadArmed <= 1'b1;
      end
    end
  end

  // ************************************************************
  // trigger control register
  // ************************************************************
  // reset value 0x7F
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      extTriggerEnable <= adc_ctl_pkg::TRIG_CTRL_RESET[adc_ctl_pkg::TRIG_EN_BIT];
    end else if (ce) begin
      if (standby) begin
        extTriggerEnable <= adc_ctl_pkg::TRIG_CTRL_RESET[adc_ctl_pkg::TRIG_EN_BIT];
      end else if (trigWrite) begin
        extTriggerEnable <= regWdata[adc_ctl_pkg::TRIG_EN_BIT];
      end
    end
  end

  // ************************************************************
  // register read path
  // ************************************************************
  // the result store answers one cycle late, so every read takes two cycles
  assign cv.rdEn  = busRead && !regAddr[3];
  assign cv.rdIdx = regAddr[2:1];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdPend <= 1'b0;
      rdAddr <= 4'h0;
    end else if (ce) begin
      rdPend <= busRead;
      if (busRead) begin
        rdAddr <= regAddr;
      end
    end
  end

  // register views as the bus sees them
  always_comb begin
    ctrlView = {convEndFlag, endIrqEnable, convStartBit, scanMode,
                convTimeSelect, groupSelect, channelSel};
    trigView = {extTriggerEnable, adc_ctl_pkg::TRIG_FIXED_ONES[6:0]};
  end

  // read data multiplexer
  always_comb begin
    case (rdAddr)
      adc_ctl_pkg::OFF_RESULT_A_HI,
      adc_ctl_pkg::OFF_RESULT_B_HI,
      adc_ctl_pkg::OFF_RESULT_C_HI,
      adc_ctl_pkg::OFF_RESULT_D_HI: begin
        next_rdata = cv.rdData[9:2];
      end
      adc_ctl_pkg::OFF_RESULT_A_LO,
      adc_ctl_pkg::OFF_RESULT_B_LO,
      adc_ctl_pkg::OFF_RESULT_C_LO,
      adc_ctl_pkg::OFF_RESULT_D_LO: begin
        // correct only after an upper read
        next_rdata = holdLatch;
      end
      adc_ctl_pkg::OFF_CTRL_STATUS: begin
        next_rdata = ctrlView;
      end
      adc_ctl_pkg::OFF_TRIG_CTRL: begin
        next_rdata = trigView;
      end
      default: begin
        next_rdata = adc_ctl_pkg::UNMAPPED_READ;
      end
    endcase
  end

  // low two bits left-justified, rest zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdLatch <= 8'h00;
    end else if (ce) begin
      if (rdPend && !rdAddr[3] && !rdAddr[0]) begin
        holdLatch <= {cv.rdData[1:0], 6'h00};
      end
    end
  end

  // answer registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
      regAck   <= 1'b0;
    end else if (ce) begin
      regAck <= rdPend;
      if (rdPend) begin
        regRdata <= next_rdata;
      end
    end
  end

  // ************************************************************
  // outputs to the analog core and interrupt controller
  // ************************************************************
  // results wiped by standby through the store clear
  // request follows flag and enable, one cycle behind
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampleChannel <= 3'h0;
      convBusy      <= 1'b0;
      convEndIrq    <= 1'b0;
    end else if (ce) begin
      sampleChannel <= {groupSelect, next_activeChan};
      convBusy      <= (next_seqState == ST_CONVERT) && !standby;
      convEndIrq    <= convEndFlag && endIrqEnable;
    end
  end

endmodule
`default_nettype wire

// ==== dv/analog_model.sv ====
// Purpose: stand-in for the analog core beside the control block
// Assumes: result only has to be steady when a conversion ends
// Notes:   result encodes the channel so every store can be traced
`timescale 1ns/1ns
`default_nettype none
module analog_model (
  input  wire logic [2:0] sampleChannel,
  output var  logic [9:0] convResult
);
  // ********************
  // result pattern
  // ********************
  // channel twice in the upper byte, its low bits in the lower byte
  always_comb begin
    convResult = {sampleChannel, sampleChannel, 2'b10, sampleChannel[1:0]};
  end
endmodule
`default_nettype wire

// ==== dv/adc_control_and_readout_props.sv ====
// Purpose: port-level properties of the converter control block
// Assumes: ce low only while the bus and the converter are quiet
// Notes:   a read answer is matched to its request two cycles back
`timescale 1ns/1ns
`default_nettype none
module adc_control_and_readout_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ce,
  input wire logic       standby,
  input wire logic       regSel,
  input wire logic [3:0] regAddr,
  input wire logic       regRead,
  input wire logic       regWrite,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       regAck,
  input wire logic       extTriggerIn,
  input wire logic [9:0] convResult,
  input wire logic [2:0] sampleChannel,
  input wire logic       convBusy,
  input wire logic       convEndIrq
);
  // ********************
  // helpers
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       rdReq;
  logic       ctlWr;
  logic [8:0] hold;
  assign rdReq = regSel && regRead && ce;
  assign ctlWr = regSel && regWrite && ce && regAddr == 4'h8;
  // cycles on the current channel; a scan step is judged by it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold <= 9'h000;
    end else begin
      hold <= ($changed(sampleChannel) || !convBusy) ? 9'h000 : hold + 9'h001;
    end
  end
  // ********************
  // properties
  // ********************
  AST_ACK_LAT: assert property (rdReq |-> ##2 regAck)
    else $error("read answer missing");
  AST_ACK_ONLY: assert property (regAck |-> $past(rdReq, 2))
    else $error("read answer without request");
  AST_TRIG_ONES: assert property (regAck && $past(regAddr, 2) == 4'h9 |-> regRdata[6:0] == 7'h7F)
    else $error("trigger low bits not ones");
  AST_LOW_ZERO: assert property (regAck && $past(regAddr, 2) < 4'h8 && $past(regAddr[0], 2) |-> regRdata[5:0] == 6'h00)
    else $error("result low byte padding not zero");
  AST_UNMAPPED: assert property (regAck && $past(regAddr, 2) > 4'h9 |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  AST_STANDBY: assert property (standby && ce |-> ##2 (!convBusy && !convEndIrq))
    else $error("standby left converter running");
  AST_START: assert property (ctlWr && regWdata[5] && !convBusy |-> ##2 convBusy)
    else $error("start bit did not launch");
  AST_STOP: assert property (ctlWr && !regWdata[5] |-> ##[1:3] !convBusy)
    else $error("clearing start did not stop");
  // the first step counts its whole length, later steps count one less
  AST_SCAN_STEP: assert property ($changed(sampleChannel) && convBusy && $past(convBusy) && hold > 9'h004
    |-> hold inside {9'd127, 9'd134, 9'd255, 9'd266})
    else $error("scan step length wrong");
endmodule
bind adc_control_and_readout adc_control_and_readout_props adc_control_and_readout_props_inst (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .standby(standby), .regSel(regSel), .regAddr(regAddr),
  .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
  .extTriggerIn(extTriggerIn), .convResult(convResult), .sampleChannel(sampleChannel),
  .convBusy(convBusy), .convEndIrq(convEndIrq)
);
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: register-level test of the converter control block
// Assumes: ce high except one freeze check; analog core replaced by a pattern model
// Notes:   reads wait for regAck within three cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  logic       clk;
  logic       sys_rst;
  logic       ce;
  logic       standby;
  logic       regSel;
  logic [3:0] regAddr;
  logic       regRead;
  logic       regWrite;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic       regAck;
  logic       extTriggerIn;
  logic [9:0] convResult;
  logic [2:0] sampleChannel;
  logic       convBusy;
  logic       convEndIrq;
  logic [7:0] rdData;
  logic [7:0] sel;
  logic [7:0] ie;
  int         bad_count;
  int         check_count;
  int         cycles;
  adc_control_and_readout adc_control_and_readout_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .standby(standby), .regSel(regSel), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck), .extTriggerIn(extTriggerIn),
    .convResult(convResult), .sampleChannel(sampleChannel), .convBusy(convBusy), .convEndIrq(convEndIrq));
  analog_model analog_model_inst (.sampleChannel(sampleChannel), .convResult(convResult));
  // ********************
  // bus tasks
  // ********************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regSel <= 1'b1;
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regSel <= 1'b0;
    regWrite <= 1'b0;
  endtask
  // data stays unknown if no answer comes, so a lost read never matches
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regSel <= 1'b1;
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regSel <= 1'b0;
    regRead <= 1'b0;
    d = 8'hXX;
    repeat (3) begin
      @(negedge clk);
      if (regAck === 1'b1) d = regRdata;
    end
  endtask
  task automatic chk(input logic [3:0] a, input logic [7:0] e, input string nm);
    rd(a, rdData);
    `CHK(nm, e, rdData)
  endtask
  task automatic waitIdle();
    repeat (3) @(posedge clk);
    for (int i = 0; i < 400 && convBusy !== 1'b0; i++) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ********************
  // clock and hang guard
  // ********************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  // ********************
  // sequence
  // ********************
  initial begin
    {sys_rst, standby, regSel, regRead, regWrite, regAddr, regWdata} = {1'b1, 16'h0000};
    extTriggerIn = 1'b1;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    chk(4'h8, 8'h00, "status");
    chk(4'h9, 8'h7F, "trigger");
    chk(4'h0, 8'h00, "result");
    chk(4'hC, 8'h00, "unmapped");
    wr(4'h9, 8'h00);
    chk(4'h9, 8'h7F, "trigger");
    // every channel once; settings only change while stopped
    for (int ch = 0; ch < 8; ch++) begin
      ie = (ch == 3) ? 8'h00 : 8'h40;
      sel = ie | 8'(ch);
      wr(4'h8, sel | 8'h20);
      waitIdle();
      `CHK("busy", 1'b0, convBusy)
      repeat (2) @(posedge clk);
      `CHK("irq", ie[6], convEndIrq)
      wr(4'h8, sel);
      chk(4'h8, sel | 8'h80, "flag");
      wr(4'h8, sel);
      chk(4'h8, sel, "flag");
      `CHK("irq", 1'b0, convEndIrq)
      chk(4'(2 * (ch % 4)), {3'(ch), 3'(ch), 2'b10}, "upper");
      chk(4'(2 * (ch % 4) + 1), {2'(ch), 6'h00}, "lower");
    end
    chk(4'h0, 8'h92, "upper");
    chk(4'h7, 8'h00, "latch");
    wr(4'h9, 8'h80);
    wr(4'h8, 8'h48);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    chk(4'h8, 8'h00, "status");
    chk(4'h9, 8'h7F, "trigger");
    chk(4'h2, 8'h00, "result");
    // fast scan over the first four channels
    wr(4'h8, 8'h3B);
    for (int i = 0; i < 700 && rdData !== 8'hBB; i++) rd(4'h8, rdData);
    `CHK("scan", 8'hBB, rdData)
    `CHK("busy", 1'b1, convBusy)
    for (int i = 0; i < 4; i++) chk(4'(2 * i), {3'(i), 3'(i), 2'b10}, "scan");
    wr(4'h8, 8'h1B);
    waitIdle();
    `CHK("busy", 1'b0, convBusy)
    // external trigger, enabled then disabled
    wr(4'h9, 8'h80);
    chk(4'h9, 8'hFF, "trigger");
    wr(4'h8, 8'h41);
    extTriggerIn <= 1'b0;
    for (int i = 0; i < 10 && convBusy !== 1'b1; i++) @(posedge clk);
    `CHK("trigger", 1'b1, convBusy)
    waitIdle();
    extTriggerIn <= 1'b1;
    wr(4'h9, 8'h00);
    extTriggerIn <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("trigger", 1'b0, convBusy)
    // with the enable low a start write must leave no trace
    ce <= 1'b0;
    wr(4'h8, 8'h20);
    ce <= 1'b1;
    chk(4'h8, 8'hC1, "freeze");
    conclude();
  end
endmodule
`default_nettype wire
